// file: lss_regs.vh
// Register offsets, control field positions and reset values of the logic slice
`ifndef LSS_REGS_VH
`define LSS_REGS_VH

`define LSS_ADDR_W          8
`define LSS_OFF_CTRL        8'h00
`define LSS_OFF_LOWER_TABLE 8'h04
`define LSS_OFF_UPPER_TABLE 8'h08
`define LSS_OFF_STATUS      8'h0C
`define LSS_OFF_STAGES      8'h10

`define LSS_CTRL_RESET      32'h0000_0000
`define LSS_TABLE_RESET     16'h0000
`define LSS_CTRL_W          23

`define LSS_B_LOWER_SHIFT   0
`define LSS_B_UPPER_SHIFT   1
`define LSS_B_LOWER_OSEL    2
`define LSS_B_UPPER_OSEL    3
`define LSS_B_LOWER_DSEL    4
`define LSS_B_UPPER_DSEL    5
`define LSS_B_LOWER_GSEL    6
`define LSS_B_UPPER_GSEL    7
`define LSS_B_CARRY_START   8
`define LSS_B_WIDE_EN       9
`define LSS_B_REV_EN        10
`define LSS_B_EXPORT_EN     11
`define LSS_B_CASCADE_IN    12
`define LSS_B_INTRA_CASC    13
`define LSS_B_INV_CLK       14
`define LSS_B_INV_CE        15
`define LSS_B_INV_SR        16
`define LSS_B_INV_BX        17
`define LSS_B_INV_BY        18
`define LSS_B_CE_USED       19
`define LSS_B_LOWER_INIT    20
`define LSS_B_UPPER_INIT    21
`define LSS_B_BYPASS_EN     22

`endif

// file: lss_table.v
// One lookup table that can also act as a 16-stage addressable shift register
`timescale 1ns/1ns
`default_nettype none

module lss_table (
  input  wire        clk,
  input  wire        shift_mode,
  input  wire        shift_en,
  input  wire        serial_in,
  input  wire [3:0]  addr,
  input  wire [15:0] table_bits,
  output wire        data_out,
  output wire        last_stage,
  output wire [15:0] stages
);

  reg [15:0] stage;

  // No reset on purpose: contents change only by shifting, so they start unknown
  always @(posedge clk)
  begin
    if (shift_mode && shift_en)
      stage <= {stage[14:0], serial_in};
  end

  // Address 0 is the newest stage, one shift of delay
  assign data_out   = shift_mode ? stage[addr] : table_bits[addr];
  assign last_stage = stage[15];
  assign stages     = stage;

endmodule // lss_table

`default_nettype wire

// file: lss_slice.v
// Programmable logic slice: two table halves, carry, wide mux, flip-flops, APB config
`timescale 1ns/1ns
`default_nettype none
`include "lss_regs.vh"

module lss_slice #(
  parameter MEMORY_CAPABLE = 1
) (
  input  wire        clk,
  input  wire        nrst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [3:0]  lower_lut_in,
  input  wire [3:0]  upper_lut_in,
  input  wire        lower_bypass_in,
  input  wire        upper_bypass_in,
  input  wire        carry_in,
  input  wire        cascade_shift_in,
  input  wire        slice_clk,
  input  wire        slice_ce,
  input  wire        set_reset_in,
  output reg         lower_comb_out,
  output reg         upper_comb_out,
  output reg         lower_registered_out,
  output reg         upper_registered_out,
  output reg         lower_carry_or_shift_out,
  output reg         upper_carry_or_shift_out,
  output reg         carry_out,
  output reg         wide_function_out,
  output reg         lower_bypass_out,
  output reg         upper_bypass_out,
  output reg         upper_bypass_export,
  output reg         cascade_shift_out
);

  reg        rst_meta;
  reg        rst_n;
  reg [31:0] ctrl;
  reg [15:0] lower_table_bits;
  reg [15:0] upper_table_bits;
  reg        slice_clk_prev;

  wire        lower_d;
  wire        upper_d;
  wire        lower_last;
  wire        upper_last;
  wire [15:0] lower_stages;
  wire [15:0] upper_stages;

  // Reset release through two flops
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  function is_mapped;
    input [7:0] off;
    begin
      is_mapped = (off == `LSS_OFF_CTRL) || (off == `LSS_OFF_LOWER_TABLE) ||
                  (off == `LSS_OFF_UPPER_TABLE) || (off == `LSS_OFF_STATUS) ||
                  (off == `LSS_OFF_STAGES);
    end
  endfunction

  // Polarity-adjusted control inputs
  wire inv_clk   = ctrl[`LSS_B_INV_CLK];
  wire bx        = lower_bypass_in ^ ctrl[`LSS_B_INV_BX];
  wire by        = upper_bypass_in ^ ctrl[`LSS_B_INV_BY];
  wire sr        = set_reset_in ^ ctrl[`LSS_B_INV_SR];
  // An unused enable is treated as always active
  wire ce_eff    = ctrl[`LSS_B_CE_USED] ? (slice_ce ^ ctrl[`LSS_B_INV_CE]) : 1'b1;

  // The slice clock is a level from fabric logic sampled on clk; the chosen edge
  // of it is the active edge. It must stay stable at least one clk period per phase.
  wire slice_edge = ((slice_clk ^ inv_clk) == 1'b1) && ((slice_clk_prev ^ inv_clk) == 1'b0);
  wire slice_tick = slice_edge && ce_eff;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      slice_clk_prev <= 1'b0;
    else
      slice_clk_prev <= slice_clk;
  end

  wire mem_ok      = (MEMORY_CAPABLE != 0);
  wire lower_shift = ctrl[`LSS_B_LOWER_SHIFT] & mem_ok;
  wire upper_shift = ctrl[`LSS_B_UPPER_SHIFT] & mem_ok;

  // Serial inputs: upper from bypass or the slice above, lower from bypass or upper's tail
  wire upper_serial = ctrl[`LSS_B_CASCADE_IN] ? cascade_shift_in : by;
  wire lower_serial = ctrl[`LSS_B_INTRA_CASC] ? upper_last : bx;

  // Both tables share the one tick
  lss_table u_lower_table (
    .clk        (clk),
    .shift_mode (lower_shift),
    .shift_en   (slice_tick),
    .serial_in  (lower_serial),
    .addr       (lower_lut_in),
    .table_bits (lower_table_bits),
    .data_out   (lower_d),
    .last_stage (lower_last),
    .stages     (lower_stages)
  );

  lss_table u_upper_table (
    .clk        (clk),
    .shift_mode (upper_shift),
    .shift_en   (slice_tick),
    .serial_in  (upper_serial),
    .addr       (upper_lut_in),
    .table_bits (upper_table_bits),
    .data_out   (upper_d),
    .last_stage (upper_last),
    .stages     (upper_stages)
  );

  // Carry chain and arithmetic
  wire carry_start = ctrl[`LSS_B_CARRY_START] ? bx : carry_in;
  wire lower_gen   = ctrl[`LSS_B_LOWER_GSEL] ? bx : lower_lut_in[0];
  wire upper_gen   = ctrl[`LSS_B_UPPER_GSEL] ? by : upper_lut_in[0];
  wire lower_carry = lower_d ? carry_start : lower_gen;
  wire upper_carry = upper_d ? lower_carry : upper_gen;
  wire lower_sum   = lower_d ^ carry_start;
  wire upper_sum   = upper_d ^ lower_carry;

  wire x_comb = ctrl[`LSS_B_LOWER_OSEL] ? lower_sum : lower_d;
  wire y_comb = ctrl[`LSS_B_UPPER_OSEL] ? upper_sum : upper_d;

  // Wide mux: with the wide enable clear it passes the lower table only
  wire wide_sel = ctrl[`LSS_B_WIDE_EN] & bx;
  wire wide_w   = wide_sel ? upper_d : lower_d;

  // Flip-flop data selection; a table in shift mode gives the addressed stage here
  wire lower_ff_d = ctrl[`LSS_B_LOWER_DSEL] ? bx : x_comb;
  wire upper_ff_d = ctrl[`LSS_B_UPPER_DSEL] ? by : y_comb;
  wire reverse_set_reset        = ctrl[`LSS_B_REV_EN] & by;
  wire lower_init = ctrl[`LSS_B_LOWER_INIT];
  wire upper_init = ctrl[`LSS_B_UPPER_INIT];

  // Set/reset beats reverse; both act on active edges only, as does the enable
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lower_registered_out <= 1'b0;
      upper_registered_out <= 1'b0;
    end
    else if (slice_tick)
    begin
      if (sr)
      begin
        lower_registered_out <= lower_init;
        upper_registered_out <= upper_init;
      end
      else if (reverse_set_reset)
      begin
        lower_registered_out <= ~lower_init;
        upper_registered_out <= ~upper_init;
      end
      else
      begin
        lower_registered_out <= lower_ff_d;
        upper_registered_out <= upper_ff_d;
      end
    end
  end

  // Combinational paths are retimed by one clk so every port comes from a flop
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lower_comb_out           <= 1'b0;
      upper_comb_out           <= 1'b0;
      lower_carry_or_shift_out <= 1'b0;
      upper_carry_or_shift_out <= 1'b0;
      carry_out                <= 1'b0;
      wide_function_out        <= 1'b0;
      lower_bypass_out         <= 1'b0;
      upper_bypass_out         <= 1'b0;
      upper_bypass_export      <= 1'b0;
      cascade_shift_out        <= 1'b0;
    end
    else
    begin
      lower_comb_out           <= x_comb;
      upper_comb_out           <= y_comb;
      lower_carry_or_shift_out <= lower_shift ? lower_last : lower_carry;
      upper_carry_or_shift_out <= upper_shift ? upper_last : upper_carry;
      carry_out                <= upper_carry;
      wide_function_out        <= wide_w;
      lower_bypass_out         <= ctrl[`LSS_B_BYPASS_EN] & bx;
      upper_bypass_out         <= ctrl[`LSS_B_BYPASS_EN] & by;
      upper_bypass_export      <= ctrl[`LSS_B_EXPORT_EN] & by;
      cascade_shift_out        <= mem_ok & lower_last;
    end
  end

  // APB slave: one wait-free access phase, answer registered in the setup cycle
  wire [7:0] off      = paddr[7:0];
  wire       setup    = psel && !penable;
  wire       wr_fire  = psel && penable && pready && pwrite;
  wire       addr_ok  = is_mapped(off) && (paddr[31:8] == 24'h000000);

  wire [31:0] status_word = {20'h00000,
                             upper_last, lower_last,
                             upper_registered_out, lower_registered_out,
                             wide_w, upper_carry, lower_carry,
                             upper_d, lower_d, ce_eff, sr, reverse_set_reset};

  reg [31:0] read_word;

  always @*
  begin
    read_word = 32'h0000_0000;
    case (off)
      `LSS_OFF_CTRL:        read_word = ctrl;
      `LSS_OFF_LOWER_TABLE: read_word = {16'h0000, lower_table_bits};
      `LSS_OFF_UPPER_TABLE: read_word = {16'h0000, upper_table_bits};
      `LSS_OFF_STATUS:      read_word = status_word;
      `LSS_OFF_STAGES:      read_word = {upper_stages, lower_stages};
      default:              read_word = 32'h0000_0000;
    endcase
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup && !addr_ok;
      if (setup && !pwrite && addr_ok)
        prdata <= read_word;
      else if (setup)
        prdata <= 32'h0000_0000;
    end
  end

  // Reserved control bits stay zero
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl             <= `LSS_CTRL_RESET;
      lower_table_bits <= `LSS_TABLE_RESET;
      upper_table_bits <= `LSS_TABLE_RESET;
    end
    else if (wr_fire && !pslverr)
    begin
      case (off)
        `LSS_OFF_CTRL:        ctrl <= {9'h000, pwdata[`LSS_CTRL_W-1:0]};
        `LSS_OFF_LOWER_TABLE: lower_table_bits <= pwdata[15:0];
        `LSS_OFF_UPPER_TABLE: upper_table_bits <= pwdata[15:0];
        default:              ctrl <= ctrl;
      endcase
    end
  end

endmodule // lss_slice

`default_nettype wire

// file: lss_fabric.sv
// Fabric-side model that makes one slice clock period on request
`timescale 1ns/1ns
`default_nettype none
module lss_fabric (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic req,
  output wire logic slice_clk
);
  logic [2:0] cnt;
  // Two cycles high, two low, then the clock stands low between periods
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      cnt <= 3'h0;
    else if (req && cnt == 3'h0)
      cnt <= 3'h4;
    else if (cnt != 3'h0)
      cnt <= cnt - 3'h1;
  end
  assign slice_clk = cnt > 3'h2;
endmodule // lss_fabric
`default_nettype wire

// file: lss_slice_asserts.sv
// Port-level assertions for the logic slice
`timescale 1ns/1ns
`default_nettype none
`include "lss_regs.vh"
module lss_slice_asserts (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        slice_clk,
  input wire logic        lower_registered_out,
  input wire logic        upper_registered_out,
  input wire logic        cascade_shift_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic       sc_prev;
  logic [1:0] quiet;
  wire        setup = psel && !penable;
  wire        bad   = paddr[31:8] != 24'h0 || paddr[1:0] != 2'h0 || paddr[7:0] > `LSS_OFF_STAGES;
  wire        rd_ok = pready && !pwrite;
  // Cycles since the slice clock last moved; storage may only change right after a move
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      quiet <= 2'h0;
    else if (slice_clk != sc_prev)
      quiet <= 2'h0;
    else if (quiet != 2'h3)
      quiet <= quiet + 2'h1;
  end
  always_ff @(posedge clk)
    sc_prev <= slice_clk;
  a_ready_after_setup: assert property (setup |=> pready) else $error("no answer after setup");
  a_ready_one_cycle: assert property (pready |=> !pready) else $error("answer longer than a cycle");
  a_ready_in_access: assert property (pready |-> psel && penable) else $error("answer outside access");
  a_err_unmapped: assert property (setup && bad |=> pslverr) else $error("unmapped access not refused");
  a_no_err_mapped: assert property (setup && !bad |=> !pslverr) else $error("mapped access refused");
  a_err_reads_zero: assert property (pslverr |-> prdata == 32'h0) else $error("refused read not zero");
  a_ctrl_read_mask: assert property (rd_ok && paddr == 32'h0 |-> prdata[31:`LSS_CTRL_W] == 9'h0)
    else $error("control spare bits not zero");
  a_table_read_mask: assert property (rd_ok && (paddr == 32'h4 || paddr == 32'h8) |-> prdata[31:16] == 16'h0)
    else $error("table spare bits not zero");
  a_lower_ff_tick: assert property ($changed(lower_registered_out) |-> quiet != 2'h3)
    else $error("lower flop moved without a tick");
  a_upper_ff_tick: assert property ($changed(upper_registered_out) |-> quiet != 2'h3)
    else $error("upper flop moved without a tick");
  a_cascade_tick: assert property ($changed(cascade_shift_out) |-> quiet != 2'h3)
    else $error("shift moved without a tick");
  a_reset_quiet: assert property ($rose(nrst) |-> !pready && !lower_registered_out && !upper_registered_out)
    else $error("outputs not cleared by reset");
  c_refused: cover property (pslverr);
  c_ff_moved: cover property ($changed(lower_registered_out));
  c_shift_moved: cover property ($changed(cascade_shift_out));
endmodule // lss_slice_asserts
bind lss_slice lss_slice_asserts u_asserts (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .slice_clk(slice_clk),
  .lower_registered_out(lower_registered_out), .upper_registered_out(upper_registered_out),
  .cascade_shift_out(cascade_shift_out));
`default_nettype wire

// file: lss_tb.sv
// Self-checking testbench for the logic slice
`timescale 1ns/1ns
`default_nettype none
`include "lss_regs.vh"
module tb;
  logic        clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, rdat;
  logic [3:0]  lo_in = 4'h0, up_in = 4'h0, v;
  logic        bx = 1'b0, by = 1'b0, ci = 1'b0, ce = 1'b1, sr = 1'b0, req = 1'b0, e, p;
  wire  [31:0] prdata;
  wire         pready, pslverr, slice_clk, lc, uc, lr, ur, lco, lbo, ubo, exo, cso, uco, co, wfo;
  int          failures = 0, samples_checked = 0, cycles = 0, i, j;
  lss_fabric fab (.clk(clk), .nrst(nrst), .req(req), .slice_clk(slice_clk));
  lss_slice uut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .lower_lut_in(lo_in),
    .upper_lut_in(up_in), .lower_bypass_in(bx), .upper_bypass_in(by), .carry_in(ci), .cascade_shift_in(1'b0),
    .slice_clk(slice_clk), .slice_ce(ce), .set_reset_in(sr), .lower_comb_out(lc), .upper_comb_out(uc),
    .lower_registered_out(lr), .upper_registered_out(ur), .lower_carry_or_shift_out(lco),
    .upper_carry_or_shift_out(uco), .carry_out(co), .wide_function_out(wfo), .lower_bypass_out(lbo),
    .upper_bypass_out(ubo), .upper_bypass_export(exo), .cascade_shift_out(cso));
  always #5 clk = ~clk;
  task automatic test_done();
    $display("checks %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // A hung handshake ends here rather than in a silent stall
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      test_done();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // Only the bench timeout ends a wait for the answer
    while (pready !== 1'b1)
      @(posedge clk);
    rdat = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask
  task automatic tick();
    req <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
    repeat (7) @(posedge clk);
  endtask
  task automatic settle();
    repeat (3) @(posedge clk);
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    rd(`LSS_OFF_CTRL, 32'h0);
    rd(`LSS_OFF_LOWER_TABLE, 32'h0);
    apb(1'b1, `LSS_OFF_CTRL, 32'hFFFF_BFFF);
    rd(`LSS_OFF_CTRL, 32'h007F_BFFF);
    apb(1'b1, `LSS_OFF_LOWER_TABLE, 32'hFFFF_6996);
    rd(`LSS_OFF_LOWER_TABLE, 32'h0000_6996);
    apb(1'b1, `LSS_OFF_UPPER_TABLE, 32'h0000_8000);
    rd(`LSS_OFF_UPPER_TABLE, 32'h0000_8000);
    rd(32'h14, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, `LSS_OFF_CTRL, 32'h0);
    $display("test registers done");
    for (i = 0; i < 16; i++)
    begin
      lo_in <= i[3:0];
      up_in <= i[3:0];
      settle();
      chk({uc, lc}, {i == 15, ^i[3:0]});
    end
    $display("test lookup done");
    // Carry comes from carry_in or bx; the unused source carries the opposite value
    for (j = 0; j < 4; j++)
    begin
      apb(1'b1, `LSS_OFF_CTRL, j[1] ? 32'h104 : 32'h4);
      ci <= j[1] ^ j[0];
      bx <= ~j[1] ^ j[0];
      for (i = 0; i < 3; i++)
      begin
        v = (i == 2) ? 4'h3 : i[3:0];
        p = ^v;
        lo_in <= v;
        settle();
        chk({lco, lc}, {p ? j[0] : v[0], p ^ j[0]});
      end
    end
    $display("test carry done");
    // Lower table gives parity 0 and upper gives 1 at input F, so bx picks the wide result
    apb(1'b1, `LSS_OFF_CTRL, 32'h0000_0200);
    lo_in <= 4'hF;
    up_in <= 4'hF;
    ci <= 1'b0;
    for (j = 0; j < 2; j++)
    begin
      bx <= j[0];
      settle();
      chk({wfo, co, uco}, {j[0], 1'b1, 1'b1});
    end
    $display("test wide done");
    apb(1'b1, `LSS_OFF_CTRL, 32'h0042_0800);
    for (j = 0; j < 4; j++)
    begin
      bx <= j[0];
      by <= j[1];
      settle();
      chk({lbo, ubo, exo}, {~j[0], j[1], j[1]});
    end
    $display("test bypass done");
    apb(1'b1, `LSS_OFF_CTRL, 32'h0008_0030);
    bx <= 1'b1;
    by <= 1'b0;
    tick();
    chk({lr, ur}, 2'b10);
    ce <= 1'b0;
    bx <= 1'b0;
    by <= 1'b1;
    tick();
    chk({lr, ur}, 2'b10);
    ce <= 1'b1;
    tick();
    chk({lr, ur}, 2'b01);
    apb(1'b1, `LSS_OFF_CTRL, 32'h0008_0430);
    tick();
    chk({lr, ur}, 2'b11);
    sr <= 1'b1;
    tick();
    chk({lr, ur}, 2'b00);
    sr <= 1'b0;
    $display("test flops done");
    apb(1'b1, `LSS_OFF_CTRL, 32'h0008_0001);
    bx <= 1'b0;
    repeat (16) tick();
    bx <= 1'b1;
    tick();
    bx <= 1'b0;
    for (i = 1; i <= 16; i++)
    begin
      lo_in <= 4'(i - 1);
      settle();
      chk({cso, lco, lc}, {i == 16, i == 16, 1'b1});
      if (i == 8)
      begin
        ce <= 1'b0;
        tick();
        chk(lc, 1'b1);
        ce <= 1'b1;
      end
      if (i < 16)
        tick();
    end
    $display("test shift done");
    test_done();
  end
endmodule // tb
`default_nettype wire
